/* src/pin_sync.v */
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to clock_i
module pin_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  // clock, reset and enable
  input wire clock_i,
  input wire rst_i,
  input wire enable_i,
  // pin and result
  input wire pin_i,
  output reg level_o
);
  reg stage1;
  always @(posedge clock_i) begin
    if (rst_i) begin
      stage1 <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end else if (enable_i) begin
      stage1 <= pin_i;
      level_o <= stage1;
    end
  end
endmodule

/* src/sensor_ctrl_map.vh */
// register offsets, field positions and reset values of the sensor control block
// assumes inclusion by name from the design files
`ifndef SENSOR_CTRL_MAP_VH
`define SENSOR_CTRL_MAP_VH
`define ADDR_CHIP_CTRL 8'h07
`define ADDR_BLACK_TARGET 8'h49
`define ADDR_OFFSET_G1 8'h60
`define ADDR_OFFSET_G2 8'h61
`define ADDR_OFFSET_CTRL 8'h62
`define ADDR_OFFSET_R 8'h63
`define ADDR_OFFSET_B 8'h64
`define ADDR_SOFT_RESET 8'h0d
`define RST_CHIP_CTRL 16'h0002
`define RST_BLACK_TARGET 16'h0000
`define RST_OFFSET 9'h000
`define RST_ZERO16 16'h0000
`define BIT_SIGN 8
`define BIT_RUN 1
`define BIT_SOFT_RESET 0
`define BIT_OFFSET_EN 0
`define SLAVE_ADDR7 7'h5d
`endif

/* src/sensor_offset_reset_standby_ctrl.v */
// two-wire serial slave with offset, black level, reset and standby registers
// assumes clock_i far faster than the serial clock; sda pin is open drain
// How it works
// RULE1 - bit 8 set makes offset negative
// RULE2 - low eight bits give offset magnitude
// RULE3 - four offsets, each for its colour
// RULE4 - offsets applied only when enable set
// RULE5 - black target drives digital offset output
// RULE6 - soft reset bit holds defaults until cleared
// RULE7 - reset pin low holds device reset
// RULE8 - run bit clear halts readout, powers down
// RULE9 - standby lasts until run bit set
// RULE10 - host raises standby pin afterwards
// RULE11 - slave only; master drives the clock
// RULE12 - data line driven low only when granted
// RULE13 - start, address, ack, byte, stop symbols
// RULE14 - sixteen-bit registers, address auto increments
// RULE15 - offsets read back nine bits, rest zero
`include "sensor_ctrl_map.vh"
module sensor_offset_reset_standby_ctrl (
  // clock, reset, enable
  input wire clock_i,
  input wire rst_i,
  input wire clk_en_i,
  // device pins
  input wire reset_n_i,
  input wire standby_i,
  // serial bus
  input wire serial_clock_i,
  input wire serial_bus_data_line_i,
  output reg serial_bus_data_line_o,
  output reg serial_bus_data_line_oe_n_o,
  // pixel colour selection and applied corrections
  input wire [1:0] colour_i,
  output reg [8:0] applied_offset_o,
  output reg [15:0] black_target_o,
  // status
  output reg readout_run_o,
  output reg analog_power_o,
  output reg standby_o,
  output reg in_reset_o
);
  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_ACK = 6'h04;
  localparam ST_RECV = 6'h08;
  localparam ST_SEND = 6'h10;
  localparam ST_MACK = 6'h20;
  localparam COL_G1 = 2'h0;
  localparam COL_R = 2'h1;
  localparam COL_B = 2'h2;
  localparam COL_G2 = 2'h3;

  wire scl;
  wire sda;
  wire reset_pin_n;
  wire standby_pin;
  reg scl_d;
  reg sda_d;
  reg [5:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] reg_addr;
  reg [7:0] high_byte;
  reg addr_phase;
  reg byte_low;
  reg reading;
  reg matched;
  reg have_bits;
  reg [15:0] chip_ctrl;
  reg [15:0] black_target;
  reg [8:0] off_g1;
  reg [8:0] off_g2;
  reg [8:0] off_r;
  reg [8:0] off_b;
  reg offset_en;
  reg soft_reset;
  reg [15:0] read_word;
  reg [8:0] sel_offset;

  pin_sync #(.RESET_LEVEL(1'b1)) sync_scl (.clock_i(clock_i), .rst_i(rst_i), .enable_i(clk_en_i),
    .pin_i(serial_clock_i), .level_o(scl));
  pin_sync #(.RESET_LEVEL(1'b1)) sync_sda (.clock_i(clock_i), .rst_i(rst_i), .enable_i(clk_en_i),
    .pin_i(serial_bus_data_line_i), .level_o(sda));
  pin_sync #(.RESET_LEVEL(1'b0)) sync_rst (.clock_i(clock_i), .rst_i(rst_i), .enable_i(clk_en_i),
    .pin_i(reset_n_i), .level_o(reset_pin_n));
  pin_sync #(.RESET_LEVEL(1'b0)) sync_stb (.clock_i(clock_i), .rst_i(rst_i), .enable_i(clk_en_i),
    .pin_i(standby_i), .level_o(standby_pin));

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda; // see RULE13
  wire stop_cond = scl & scl_d & ~sda_d & sda; // see RULE13
  wire pin_reset = ~reset_pin_n; // see RULE7
  wire reg_reset = rst_i | (clk_en_i & pin_reset);
  wire [7:0] shifted = {shift[6:0], sda};

  // register read mux
  always @* begin
    read_word = `RST_ZERO16;
    case (reg_addr)
      `ADDR_CHIP_CTRL: read_word = chip_ctrl;
      `ADDR_BLACK_TARGET: read_word = black_target;
      `ADDR_OFFSET_G1: read_word = {7'h00, off_g1}; // see RULE15
      `ADDR_OFFSET_G2: read_word = {7'h00, off_g2}; // see RULE15
      `ADDR_OFFSET_R: read_word = {7'h00, off_r}; // see RULE15
      `ADDR_OFFSET_B: read_word = {7'h00, off_b}; // see RULE15
      `ADDR_OFFSET_CTRL: read_word = {15'h0000, offset_en};
      `ADDR_SOFT_RESET: read_word = {15'h0000, soft_reset};
      default: read_word = `RST_ZERO16;
    endcase
  end

  // colour selection of the offset
  always @* begin
    case (colour_i)
      COL_G1: sel_offset = off_g1; // see RULE3
      COL_R: sel_offset = off_r; // see RULE3
      COL_B: sel_offset = off_b; // see RULE3
      COL_G2: sel_offset = off_g2; // see RULE3
      default: sel_offset = off_g2; // see RULE3
    endcase
  end

  // serial slave state machine
  always @(posedge clock_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      reg_addr <= 8'h00;
      high_byte <= 8'h00;
      addr_phase <= 1'b0;
      byte_low <= 1'b0;
      reading <= 1'b0;
      matched <= 1'b0;
      have_bits <= 1'b0;
      serial_bus_data_line_o <= 1'b1;
      serial_bus_data_line_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      scl_d <= scl;
      sda_d <= sda;
      if (pin_reset) begin
        state <= ST_IDLE;
        serial_bus_data_line_oe_n_o <= 1'b1;
      end else if (start_cond) begin
        state <= ST_ADDR;
        bit_cnt <= 3'h0;
        byte_low <= 1'b0;
        have_bits <= 1'b0;
        serial_bus_data_line_oe_n_o <= 1'b1;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        serial_bus_data_line_oe_n_o <= 1'b1; // see RULE12
      end else begin
        case (state)
          ST_IDLE: begin
            serial_bus_data_line_oe_n_o <= 1'b1;
          end
          ST_ADDR, ST_RECV: begin
            if (scl_rise) begin
              shift <= shifted;
              bit_cnt <= bit_cnt + 3'h1;
              have_bits <= 1'b1;
            end
            // byte ends at the fall after eight rises, not the fall after start
            if (scl_fall && bit_cnt == 3'h0 && have_bits) begin
              have_bits <= 1'b0;
              if (state == ST_ADDR) begin
                matched <= (shift[7:1] == `SLAVE_ADDR7);
                reading <= shift[0];
                addr_phase <= ~shift[0];
                if (shift[7:1] == `SLAVE_ADDR7) begin
                  serial_bus_data_line_oe_n_o <= 1'b0; // see RULE11
                  serial_bus_data_line_o <= 1'b0;
                  state <= ST_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                if (addr_phase) begin
                  reg_addr <= shift;
                  addr_phase <= 1'b0;
                end else if (!byte_low) begin
                  high_byte <= shift;
                  byte_low <= 1'b1;
                end else begin
                  byte_low <= 1'b0;
                  reg_addr <= reg_addr + 8'h01; // see RULE14
                end
                serial_bus_data_line_oe_n_o <= 1'b0; // see RULE12
                serial_bus_data_line_o <= 1'b0;
                state <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (reading) begin
                shift <= byte_low ? read_word[7:0] : read_word[15:8];
                serial_bus_data_line_o <= 1'b0;
                serial_bus_data_line_oe_n_o <= byte_low ? read_word[7] : read_word[15]; // see RULE12
                state <= ST_SEND;
              end else begin
                serial_bus_data_line_oe_n_o <= 1'b1;
                state <= ST_RECV;
              end
            end
          end
          // shift out msb first while the clock is low
          ST_SEND: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                serial_bus_data_line_oe_n_o <= 1'b1;
                state <= ST_MACK;
              end else begin
                serial_bus_data_line_oe_n_o <= shift[6];
                shift <= {shift[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda) begin
                state <= ST_IDLE;
              end else begin
                if (byte_low) begin
                  reg_addr <= reg_addr + 8'h01; // see RULE14
                end
                byte_low <= ~byte_low;
                state <= ST_ACK;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // write strobe once sixteen bits have arrived
  wire word_done = clk_en_i & ~pin_reset & ~start_cond & ~stop_cond & (state == ST_RECV) & scl_fall &
    (bit_cnt == 3'h0) & have_bits & ~addr_phase & byte_low & matched & ~reading;
  wire [15:0] wdata = {high_byte, shift};

  // soft reset bit is only cleared by writing it or by hard reset
  always @(posedge clock_i) begin
    if (reg_reset) begin
      soft_reset <= 1'b0;
    end else if (word_done && reg_addr == `ADDR_SOFT_RESET) begin
      soft_reset <= wdata[`BIT_SOFT_RESET]; // see RULE6
    end
  end

  // control and offset registers
  always @(posedge clock_i) begin
    // soft reset keeps the bank at defaults until it is cleared
    if (reg_reset || (clk_en_i && soft_reset)) begin
      chip_ctrl <= `RST_CHIP_CTRL; // see RULE6
      black_target <= `RST_BLACK_TARGET;
      off_g1 <= `RST_OFFSET;
      off_g2 <= `RST_OFFSET;
      off_r <= `RST_OFFSET;
      off_b <= `RST_OFFSET;
      offset_en <= 1'b0;
    end else if (word_done) begin
      case (reg_addr)
        `ADDR_CHIP_CTRL: chip_ctrl <= wdata; // see RULE9
        `ADDR_BLACK_TARGET: black_target <= wdata;
        `ADDR_OFFSET_G1: off_g1 <= wdata[`BIT_SIGN:0];
        `ADDR_OFFSET_G2: off_g2 <= wdata[`BIT_SIGN:0];
        `ADDR_OFFSET_R: off_r <= wdata[`BIT_SIGN:0];
        `ADDR_OFFSET_B: off_b <= wdata[`BIT_SIGN:0];
        `ADDR_OFFSET_CTRL: offset_en <= wdata[`BIT_OFFSET_EN];
        default: offset_en <= offset_en;
      endcase
    end
  end

  // applied corrections and status outputs
  always @(posedge clock_i) begin
    if (rst_i) begin
      applied_offset_o <= `RST_OFFSET;
      black_target_o <= `RST_BLACK_TARGET;
      readout_run_o <= 1'b0;
      analog_power_o <= 1'b0;
      standby_o <= 1'b0;
      in_reset_o <= 1'b1;
    end else if (clk_en_i) begin
      // sign in bit 8, magnitude in bits 7:0
      applied_offset_o <= offset_en ? sel_offset : `RST_OFFSET; // see RULE4 RULE1 RULE2
      black_target_o <= black_target; // see RULE5
      readout_run_o <= chip_ctrl[`BIT_RUN] & ~soft_reset & ~pin_reset; // see RULE8
      analog_power_o <= chip_ctrl[`BIT_RUN] & ~pin_reset; // see RULE8
      standby_o <= ~chip_ctrl[`BIT_RUN] & standby_pin; // see RULE10
      in_reset_o <= soft_reset | pin_reset; // see RULE7
    end
  end
endmodule

/* test/host_master.sv */
// host controller model, master of the two-wire serial bus
// assumes the bench forms the data wire from both release flags
module host_master (
  // clock and data wire
  input wire logic clock_i,
  input wire logic sda_i,
  // serial clock and data release
  output logic scl_o = 1'b1,
  output logic rel_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  task tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // data falls while clock high
  task start;
    tick(2); rel_o = 1'b1; tick(2); scl_o = 1'b1; tick(2); rel_o = 1'b0; tick(2); scl_o = 1'b0;
  endtask
  task stop;
    tick(2); rel_o = 1'b0; tick(2); scl_o = 1'b1; tick(2); rel_o = 1'b1; tick(2);
  endtask
  // master makes every clock pulse and only pulls low
  task bitx(input logic b, output logic r);
    tick(2); rel_o = b; tick(2); scl_o = 1'b1; tick(2); r = sda_i; tick(2); scl_o = 1'b0;
  endtask
  // eight bits msb first then acknowledge
  task byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(mack, ack);
  endtask
endmodule

/* test/sensor_ctrl_monitor.sv */
// checker of the sensor control block outputs
// assumes a bind to the control block and one clock domain
module sensor_ctrl_monitor (
  // clock, reset and pins
  input wire clock_i,
  input wire rst_i,
  input wire reset_n_i,
  input wire standby_i,
  // outputs watched
  input wire serial_bus_data_line_o,
  input wire serial_bus_data_line_oe_n_o,
  input wire [8:0] applied_offset_o,
  input wire [15:0] black_target_o,
  input wire readout_run_o,
  input wire analog_power_o,
  input wire standby_o,
  input wire in_reset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_RESET: assert property ($fell(rst_i) |-> in_reset_o && serial_bus_data_line_oe_n_o
    && applied_offset_o == 9'h000) else $error("outputs not at reset values");
  AST_DRIVE_LOW: assert property (!serial_bus_data_line_oe_n_o |-> !serial_bus_data_line_o)
    else $error("data line driven high");
  AST_RELEASE: assert property ($fell(serial_bus_data_line_oe_n_o) |-> ##[1:100] serial_bus_data_line_oe_n_o)
    else $error("data line held too long");
  AST_STANDBY_HALT: assert property (standby_o |-> !readout_run_o && !analog_power_o)
    else $error("running in standby");
  AST_POWER_RUN: assert property (!analog_power_o [*3] |-> !readout_run_o)
    else $error("readout without power");
  AST_PIN_RESET: assert property (!reset_n_i [*6] |-> in_reset_o && black_target_o == 16'h0000)
    else $error("pin reset not held");
  AST_RESET_DEFAULTS: assert property (in_reset_o [*3] |-> applied_offset_o == 9'h000)
    else $error("offset applied in reset");
  AST_PIN_STANDBY: assert property (!standby_i [*4] |-> !standby_o)
    else $error("standby without pin");
  cover property ($fell(serial_bus_data_line_oe_n_o));
  cover property (standby_o);
  cover property (in_reset_o && reset_n_i);
endmodule

bind sensor_offset_reset_standby_ctrl sensor_ctrl_monitor mon (.clock_i, .rst_i, .reset_n_i, .standby_i,
  .serial_bus_data_line_o, .serial_bus_data_line_oe_n_o, .applied_offset_o, .black_target_o,
  .readout_run_o, .analog_power_o, .standby_o, .in_reset_o);

/* test/test_sensor_offset_reset_standby_ctrl.sv */
// self-checking bench of the sensor control block
// assumes host_master as bus master and a pull-up on the data wire
module test_sensor_offset_reset_standby_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_i = 1, reset_n_i = 1, standby_i = 0;
  logic [1:0] colour_i = 0;
  wire scl, m_rel, sda_o, oe_n, run, pwr, stby, inr;
  wire [8:0] offs;
  wire [15:0] blk;
  wire sda = m_rel & (oe_n | sda_o);
  logic [15:0] mdl [0:255];
  logic [15:0] q [$];
  logic [7:0] cm [0:3] = '{8'h60, 8'h63, 8'h64, 8'h61};
  int mismatches = 0, samples_checked = 0;
  initial forever #10 clock_i = ~clock_i;
  sensor_offset_reset_standby_ctrl DUT (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(1'b1), .reset_n_i(reset_n_i),
    .standby_i(standby_i), .serial_clock_i(scl), .serial_bus_data_line_i(sda), .serial_bus_data_line_o(sda_o),
    .serial_bus_data_line_oe_n_o(oe_n), .colour_i(colour_i), .applied_offset_o(offs), .black_target_o(blk),
    .readout_run_o(run), .analog_power_o(pwr), .standby_o(stby), .in_reset_o(inr));
  host_master hm (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .rel_o(m_rel));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task mclr;
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[8'h07] = 16'h0002;
  endtask
  task mput(input logic [7:0] a, input logic [15:0] v);
    if (a == 8'h0d && v[0]) mclr();
    if (a == 8'h0d || !mdl[8'h0d][0])
      case (a)
        8'h60, 8'h61, 8'h63, 8'h64: mdl[a] = v & 16'h01ff;
        8'h07, 8'h49: mdl[a] = v;
        8'h62, 8'h0d: mdl[a] = v & 16'h0001;
        default: ;
      endcase
  endtask
  task wr(input logic [7:0] a);
    logic k;
    logic [7:0] x;
    hm.start();
    hm.byte_x(8'hba, 1'b1, x, k);
    hm.byte_x(a, 1'b1, x, k);
    foreach (q[i]) begin
      hm.byte_x(q[i][15:8], 1'b1, x, k);
      hm.byte_x(q[i][7:0], 1'b1, x, k);
      chk({15'h0000, k}, 16'h0000);
      mput(a + i, q[i]);
    end
    hm.stop();
  endtask
  task rd(input logic [7:0] a, input int n);
    logic k;
    logic [7:0] h, l;
    hm.start();
    hm.byte_x(8'hba, 1'b1, h, k);
    hm.byte_x(a, 1'b1, h, k);
    hm.start();
    hm.byte_x(8'hbb, 1'b1, h, k);
    for (int i = 0; i < n; i++) begin
      hm.byte_x(8'hff, 1'b0, h, k);
      hm.byte_x(8'hff, i == n - 1, l, k);
      chk({h, l}, mdl[a + i]);
    end
    hm.stop();
  endtask
  task ccheck;
    for (int c = 0; c < 4; c++) begin
      @(negedge clock_i) colour_i = 2'(c);
      @(negedge clock_i);
      chk({7'h00, offs}, mdl[8'h62][0] ? mdl[cm[c]] : 16'h0000);
    end
  endtask
  initial begin
    repeat (50000) @(posedge clock_i);
    mismatches++;
    print_verdict();
  end
  initial begin
    logic k;
    logic [7:0] x;
    void'($urandom(80780));
    mclr();
    repeat (8) @(posedge clock_i);
    @(negedge clock_i) rst_i = 0;
    repeat (4) @(negedge clock_i);
    rd(8'h07, 1);
    rd(8'h60, 2);
    q = {};
    repeat (5) q.push_back(16'($urandom));
    q[2] = 16'h0001;
    wr(8'h60);
    rd(8'h60, 2);
    rd(8'h63, 2);
    ccheck();
    q = {16'h0000};
    wr(8'h62);
    ccheck();
    $display("offset test done");
    q = {16'($urandom) | 16'h0100};
    wr(8'h49);
    chk(blk, mdl[8'h49]);
    q = {16'h1234};
    wr(8'h30);
    rd(8'h30, 1);
    hm.start();
    hm.byte_x(8'hb8, 1'b1, x, k);
    hm.stop();
    chk({15'h0000, k}, 16'h0001);
    $display("bus test done");
    q = {16'h0000};
    wr(8'h07);
    @(negedge clock_i) standby_i = 1;
    repeat (6) @(negedge clock_i);
    chk({13'h0000, stby, run, pwr}, 16'h0004);
    q = {16'h0002};
    wr(8'h07);
    repeat (6) @(negedge clock_i);
    chk({13'h0000, stby, run, pwr}, 16'h0003);
    standby_i = 0;
    $display("standby test done");
    q = {16'h0001};
    wr(8'h0d);
    chk({15'h0000, inr}, 16'h0001);
    chk(blk, 16'h0000);
    q = {16'h0000};
    wr(8'h0d);
    rd(8'h60, 2);
    q = {16'h5a5a};
    wr(8'h49);
    reset_n_i = 0;
    repeat (10) @(negedge clock_i);
    chk({15'h0000, inr}, 16'h0001);
    reset_n_i = 1;
    repeat (8) @(negedge clock_i);
    mclr();
    chk({inr, blk[14:0]}, 16'h0000);
    rd(8'h49, 1);
    $display("reset test done");
    print_verdict();
  end
endmodule
